// ---- src/srw_regs.svh ----
/*
 * Timing constants of the supervisor reset watchdog.
 * Assumes a single core clock of the period given here.
 */
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

`define SRW_CLK_PERIOD_NS 25
`define SRW_US_NS 1000
`define SRW_US_CYCLES (`SRW_US_NS / `SRW_CLK_PERIOD_NS)
`define SRW_TRIP_DELAY_US 6
`define SRW_TRIP_CYCLES (`SRW_TRIP_DELAY_US * `SRW_US_CYCLES)
`define SRW_PRESS_MIN_US 1
`define SRW_SYNC_LATENCY 4
`define SRW_PRESS_CYCLES ((`SRW_PRESS_MIN_US * `SRW_US_NS) / `SRW_CLK_PERIOD_NS - `SRW_SYNC_LATENCY)
`define SRW_RELEASE_BLANK_CYCLES 40
`define SRW_HOLD_FIXED_MS 200
`define SRW_HOLD_ADJ_MS 250
`define SRW_WDT_NORMAL_MS 1600
`define SRW_WDT_START_S 51

`endif

// ---- src/srw_pkg.sv ----
/*
 * Types of the supervisor reset watchdog.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package srw_pkg;

	// ==========================================================
	// Synchronised inputs
	typedef struct packed {
		logic sup_ok;
		logic aux_ok;
		logic pin;
		logic kick;
	} srw_in_t;

	// ==========================================================
	// Reset state
	typedef enum logic [2:0] {
		S_ASSERT = 3'b001,
		S_HOLD = 3'b010,
		S_RUN = 3'b100
	} srw_state_t;

endpackage : srw_pkg

// ---- src/srw_sync.sv ----
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ps
module srw_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic async_in,
	output logic level_out
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_level;

	// ==========================================================
	// The level changes only once the second and third stages agree.
	always_comb begin
		next_stage = {stage[1:0], async_in};
		next_level = level_out;
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage <= {3{RST_VAL}};
			level_out <= RST_VAL;
		end else begin
			stage <= next_stage;
			level_out <= next_level;
		end
	end

endmodule : srw_sync

// ---- src/srw_top.sv ----
/*
 * Reset generator: power-up, two voltage monitors, manual reset and watchdog.
 * Assumes digital comparator results and an external pull-up on the shared pin.
 */
`timescale 1ns/1ps
`include "srw_regs.svh"
module srw_top import srw_pkg::*; #(
	parameter int HOLD_US = `SRW_HOLD_FIXED_MS * 1000,
	parameter int WDT_NORMAL_US = `SRW_WDT_NORMAL_MS * 1000,
	parameter int WDT_START_US = `SRW_WDT_START_S * 1000000
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic supply_above_trip_in,
	input wire logic aux_voltage_monitor_in,
	input wire logic watchdog_toggle_in,
	input wire logic shared_reset_low_and_button_pin_in,
	output logic shared_reset_low_and_button_pin_out,
	output logic shared_reset_low_and_button_pin_oe,
	output logic reset_high_out
);
	localparam int US_CYC = `SRW_US_CYCLES;
	localparam int TRIP_CYC = `SRW_TRIP_CYCLES;
	localparam int PRESS_CYC = `SRW_PRESS_CYCLES;
	localparam int BLANK_CYC = `SRW_RELEASE_BLANK_CYCLES;

	srw_in_t sy;
	logic kick_prev;
	logic kick_edge;
	logic us_tick;
	logic [5:0] us_cnt, next_us_cnt;
	logic [7:0] trip_cnt, next_trip_cnt;
	logic volt_fault, next_volt_fault;
	logic low_v;
	logic [5:0] blank_cnt, next_blank_cnt;
	logic [5:0] press_cnt, next_press_cnt;
	logic press_event;
	srw_state_t state, next_state;
	logic [17:0] hold_cnt, next_hold_cnt;
	logic hold_done;
	logic [25:0] wdt_cnt, next_wdt_cnt;
	logic startup, next_startup;
	logic wdt_bite;

	// ==========================================================
	// Input synchronisers
	// A 100 ns watchdog pulse spans four clocks, enough for the filter.
	srw_sync #(.RST_VAL(1'b0)) u_sup (.core_clk(core_clk), .rst(rst),
		.async_in(supply_above_trip_in), .level_out(sy.sup_ok));
	srw_sync #(.RST_VAL(1'b0)) u_aux (.core_clk(core_clk), .rst(rst),
		.async_in(aux_voltage_monitor_in), .level_out(sy.aux_ok));
	srw_sync #(.RST_VAL(1'b0)) u_pin (.core_clk(core_clk), .rst(rst),
		.async_in(shared_reset_low_and_button_pin_in), .level_out(sy.pin));
	srw_sync #(.RST_VAL(1'b0)) u_kick (.core_clk(core_clk), .rst(rst),
		.async_in(watchdog_toggle_in), .level_out(sy.kick));

	// ==========================================================
	// Filters and microsecond divider
	assign us_tick = (us_cnt == 6'(US_CYC - 1));
	assign kick_edge = (sy.kick != kick_prev);
	assign low_v = !(sy.sup_ok && sy.aux_ok);
	assign press_event = (blank_cnt == 6'(BLANK_CYC)) && !sy.pin
		&& (press_cnt == 6'(PRESS_CYC - 1));

	always_comb begin
		next_us_cnt = us_tick ? 6'h00 : us_cnt + 6'h01;
		// Every hold starts on a fresh microsecond, so its length ignores the divider phase.
		if (state == S_ASSERT || press_event || wdt_bite) begin
			next_us_cnt = 6'h00;
		end
		next_trip_cnt = 8'h00;
		next_volt_fault = 1'b0;
		if (low_v) begin
			// A dip must persist for the trip delay before it counts.
			next_trip_cnt = volt_fault ? trip_cnt : trip_cnt + 8'h01;
			next_volt_fault = volt_fault || (trip_cnt == 8'(TRIP_CYC - 1));
		end
		// The pin reads low while we drive it, so it is blanked after release.
		next_blank_cnt = 6'h00;
		if (state == S_RUN) begin
			next_blank_cnt = (blank_cnt == 6'(BLANK_CYC)) ? blank_cnt : blank_cnt + 6'h01;
		end
		next_press_cnt = 6'h00;
		if ((blank_cnt == 6'(BLANK_CYC)) && !sy.pin && !press_event) begin
			next_press_cnt = press_cnt + 6'h01;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			us_cnt <= 6'h00;
			trip_cnt <= 8'h00;
			volt_fault <= 1'b1;
			blank_cnt <= 6'h00;
			press_cnt <= 6'h00;
			kick_prev <= 1'b0;
		end else begin
			us_cnt <= next_us_cnt;
			trip_cnt <= next_trip_cnt;
			volt_fault <= next_volt_fault;
			blank_cnt <= next_blank_cnt;
			press_cnt <= next_press_cnt;
			kick_prev <= sy.kick;
		end
	end

	// ==========================================================
	// Reset state machine
	assign hold_done = us_tick && (hold_cnt == 18'(HOLD_US - 1));

	always_comb begin
		next_state = state;
		next_hold_cnt = hold_cnt;
		case (state)
			S_ASSERT: begin
				next_hold_cnt = 18'h00000;
				if (!volt_fault) begin
					next_state = S_HOLD;
				end
			end
			S_HOLD: begin
				if (volt_fault) begin
					next_state = S_ASSERT;
					next_hold_cnt = 18'h00000;
				end else if (press_event) begin
					next_hold_cnt = 18'h00000;
				end else if (hold_done) begin
					next_state = S_RUN;
				end else if (us_tick) begin
					next_hold_cnt = hold_cnt + 18'h00001;
				end
			end
			S_RUN: begin
				next_hold_cnt = 18'h00000;
				if (volt_fault) begin
					next_state = S_ASSERT;
				end else if (press_event || wdt_bite) begin
					next_state = S_HOLD;
				end
			end
			default: begin
				next_state = S_ASSERT;
				next_hold_cnt = 18'h00000;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= S_ASSERT;
			hold_cnt <= 18'h00000;
		end else begin
			state <= next_state;
			hold_cnt <= next_hold_cnt;
		end
	end

	// Both outputs come from the same state flops, so they never skew.
	assign reset_high_out = (state != S_RUN);
	assign shared_reset_low_and_button_pin_oe = (state != S_RUN);
	assign shared_reset_low_and_button_pin_out = 1'b0;

	// ==========================================================
	// Watchdog
	// The long startup period lets software boot before the first toggle.
	assign wdt_bite = (state == S_RUN) && us_tick && !kick_edge && !press_event
		&& (wdt_cnt == (startup ? 26'(WDT_START_US - 1) : 26'(WDT_NORMAL_US - 1)));

	always_comb begin
		next_wdt_cnt = wdt_cnt;
		next_startup = startup;
		if (state != S_RUN || press_event) begin
			next_wdt_cnt = 26'h0000000;
		end else if (kick_edge) begin
			next_wdt_cnt = 26'h0000000;
			next_startup = 1'b0;
		end else if (wdt_bite) begin
			next_wdt_cnt = 26'h0000000;
			next_startup = 1'b0;
		end else if (us_tick) begin
			next_wdt_cnt = wdt_cnt + 26'h0000001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wdt_cnt <= 26'h0000000;
			startup <= 1'b1;
		end else begin
			wdt_cnt <= next_wdt_cnt;
			startup <= next_startup;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_trip_qualified;
		low_v && !volt_fault && (trip_cnt == 8'(TRIP_CYC - 1));
	endsequence
	sequence s_reset_held;
		reset_high_out [*8];
	endsequence
	property p_trip_reset;
		s_trip_qualified |=> volt_fault ##1 s_reset_held;
	endproperty

	a_pin_mirror: assert property (shared_reset_low_and_button_pin_oe == reset_high_out
		&& !shared_reset_low_and_button_pin_out) else $error("reset pins differ");
	a_power_up_reset: assert property ($fell(rst) |-> reset_high_out)
		else $error("no reset at power-up");
	a_trip_to_reset: assert property (p_trip_reset)
		else $error("trip not followed by reset");
	a_trip_not_early: assert property (low_v && !volt_fault && trip_cnt < 8'(TRIP_CYC - 1)
		|=> !volt_fault || $past(volt_fault)) else $error("trip too early");
	a_release_after_hold: assert property ($fell(reset_high_out) |-> $past(hold_done)
		&& $past(state) == S_HOLD) else $error("release before hold");
	a_hold_restart: assert property (state == S_HOLD && volt_fault
		|=> state == S_ASSERT && hold_cnt == 18'h00000) else $error("hold kept");
	a_press_resets: assert property (press_event && state == S_RUN && !volt_fault
		|=> state == S_HOLD ##1 s_reset_held) else $error("manual reset lost");
	a_wdt_edge_clear: assert property (kick_edge && state == S_RUN
		|=> wdt_cnt == 26'h0000000) else $error("edge did not clear");
	a_wdt_reset_clear: assert property (reset_high_out [*2] |-> wdt_cnt == 26'h0000000)
		else $error("watchdog runs in reset");
	a_startup_quiet: assert property (startup && us_tick && wdt_cnt == 26'(WDT_NORMAL_US - 1)
		|-> !wdt_bite) else $error("bite during startup");
	a_normal_bite: assert property (!startup && state == S_RUN && us_tick && !kick_edge
		&& !press_event && !volt_fault && wdt_cnt == 26'(WDT_NORMAL_US - 1)
		|=> state == S_HOLD) else $error("watchdog did not expire");

endmodule : srw_top

// ---- bench/srw_host_model.sv ----
/*
 * Processor model: it toggles the watchdog input and presses the shared reset button.
 * Assumes that the bench resolves the open-drain pin from button_low and the design enable.
 */
`timescale 1ns/1ps
module srw_host_model #(
	parameter int KICK_CYC = 400,
	parameter int PRESS_CYC = 80
) (
	input wire logic core_clk,
	input wire logic kick_en,
	input wire logic press,
	output logic watchdog_toggle_in,
	output logic button_low
);
	int kcnt = 0;
	int pcnt = 0;
	initial begin
		watchdog_toggle_in = 1'b0;
		button_low = 1'b0;
	end
	// ==========================================================
	// Stimulus
	// Signals change 1 ns after the edge, so the bench's 2 ns writes never race them.
	always @(posedge core_clk) begin
		#1;
		kcnt = kick_en ? kcnt + 1 : 0;
		if (kcnt >= KICK_CYC) begin
			kcnt = 0;
			watchdog_toggle_in = ~watchdog_toggle_in;
		end
		if (press && pcnt == 0) pcnt = PRESS_CYC;
		button_low = (pcnt > 0);
		if (pcnt > 0) pcnt = pcnt - 1;
	end
endmodule : srw_host_model

// ---- bench/srw_top_test.sv ----
/*
 * Self-checking bench of the reset generator, with short hold and watchdog counts.
 * Assumes a 40 MHz clock and a pull-up on the shared open-drain pin.
 */
`timescale 1ns/1ps
module srw_top_test;
	typedef struct {logic sup; logic aux; int len; logic exp;} srw_row_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic sup_in = 1'b1;
	logic aux_in = 1'b1;
	logic kick_en = 1'b0;
	logic press = 1'b0;
	logic wdt_in, button_low, pin_out, pin_oe, reset_high_out;
	wire logic pin_wire = ((pin_oe === 1'b1 && pin_out === 1'b0) || button_low) ? 1'b0 : 1'b1;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc_cnt = 0;
	int n;
	srw_row_t rows[5] = '{'{0, 1, 100, 0}, '{0, 1, 300, 1}, '{1, 0, 100, 0}, '{1, 0, 300, 1},
		'{0, 0, 300, 1}};
	always #12.5 core_clk = ~core_clk;
	srw_top #(.HOLD_US(5), .WDT_NORMAL_US(40), .WDT_START_US(80)) dut (
		.core_clk(core_clk),
		.rst(rst),
		.supply_above_trip_in(sup_in),
		.aux_voltage_monitor_in(aux_in),
		.watchdog_toggle_in(wdt_in),
		.shared_reset_low_and_button_pin_in(pin_wire),
		.shared_reset_low_and_button_pin_out(pin_out),
		.shared_reset_low_and_button_pin_oe(pin_oe),
		.reset_high_out(reset_high_out)
	);
	srw_host_model host (
		.core_clk(core_clk),
		.kick_en(kick_en),
		.press(press),
		.watchdog_toggle_in(wdt_in),
		.button_low(button_low)
	);
	// ==========================================================
	// Checking
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask : chk_bit
	task automatic chk_range(input int got, input int lo, input int hi, input string msg);
		num_checks++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s took %0d cycles", $time, msg, got);
		end
	endtask : chk_range
	task automatic wait_rst(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (reset_high_out !== v && cnt < lim) begin
			@(posedge core_clk);
			#2;
			cnt++;
		end
	endtask : wait_rst
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	always @(negedge core_clk) begin
		if (!rst) begin
			chk_bit(pin_oe, reset_high_out, "low output differs");
			chk_bit(pin_out, 1'b0, "pin driven high");
		end
	end
	// The ceiling is about twice the length of the planned sequence.
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			error_cnt++;
			$display("MISMATCH at %0t: timeout", $time);
			finish_test();
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		repeat (16) @(posedge core_clk);
		#2;
		rst = 1'b0;
		chk_bit(reset_high_out, 1'b1, "no power-up reset");
		wait_rst(1'b0, 1000, n);
		chk_range(n, 195, 250, "power-up hold");
		$display("test power-up done");
		foreach (rows[i]) begin
			sup_in = rows[i].sup;
			aux_in = rows[i].aux;
			repeat (rows[i].len) @(posedge core_clk);
			#2;
			chk_bit(reset_high_out, rows[i].exp, "dip response");
			sup_in = 1'b1;
			aux_in = 1'b1;
			if (rows[i].exp) begin
				wait_rst(1'b0, 400, n);
				chk_range(n, 195, 250, "recovery hold");
			end
		end
		$display("test monitors done");
		wait_rst(1'b1, 4000, n);
		chk_range(n, 3150, 3260, "startup watchdog");
		wait_rst(1'b0, 400, n);
		wait_rst(1'b1, 2000, n);
		chk_range(n, 1550, 1660, "normal watchdog");
		wait_rst(1'b0, 400, n);
		kick_en = 1'b1;
		wait_rst(1'b1, 8000, n);
		chk_range(n, 8000, 8000, "kicked watchdog");
		$display("test watchdog done");
		press = 1'b1;
		@(posedge core_clk);
		#2;
		press = 1'b0;
		wait_rst(1'b1, 100, n);
		chk_range(n, 35, 46, "manual press");
		wait_rst(1'b0, 600, n);
		chk_range(n, 190, 260, "manual hold");
		wait_rst(1'b1, 2000, n);
		chk_range(n, 2000, 2000, "kicks after press");
		$display("test manual done");
		rst = 1'b1;
		repeat (4) @(posedge core_clk);
		#2;
		chk_bit(reset_high_out, 1'b1, "no reset during mid-run rst");
		rst = 1'b0;
		wait_rst(1'b0, 1000, n);
		chk_range(n, 195, 250, "hold after mid-run reset");
		$display("test mid-run reset done");
		finish_test();
	end
endmodule : srw_top_test
